// ===== core/tap_pkg.sv
// Constants, state codes and instruction codes for the memory's scan port.
// Assumes a 40 MHz system clock that oversamples the scan clock pin.
package tap_pkg;

   // Instruction register layout and codes
   localparam int IR_W = 3;
   localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
   localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

   // Data register lengths
   localparam int BSR_LEN_X36 = 73;
   localparam int BSR_LEN_X18 = 54;
   localparam int ID_W = 32;
   // Arbitrary identification value, least significant bit set
   localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h0c0d_e001;

   // Controller reset sequence and sampling
   localparam int RESET_ONES = 5;
   localparam logic [2:0] PIN_RST = 3'h3;
   localparam int SNAP_DEPTH_DEF = 8;

   // Timing: the scan clock is at least four system clocks long
   localparam int CLK_PERIOD_NS = 25;
   localparam int TCK_MIN_PERIOD_NS = 100;
   localparam int TCK_MIN_CLKS = (TCK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Controller states, one-hot
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001,
      ST_IDLE = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } tap_state_e;

   // Data register chosen by the instruction
   typedef enum logic [2:0] {
      SEL_BYPASS = 3'h1,
      SEL_ID = 3'h2,
      SEL_BSR = 3'h4
   } dr_sel_e;

endpackage

// ===== core/pin_sync.sv
// Two-flop synchroniser for a group of pins from outside the clock domain.
// Assumes each bit is a slow level; a vector is only coherent while held stable.
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q, meta_d;
   logic [W-1:0] sync_q, sync_d;

   // First stage feeds only the second
   always_comb begin
      meta_d = meta_q;
      sync_d = sync_q;
      if (ce) begin
         meta_d = async_in;
         sync_d = meta_q;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

// ===== core/snap_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes the reader may stall; a write while full is refused by in_ready low.
module snap_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   // Pointer and count bookkeeping
   always_comb begin
      push = ce && in_valid && in_ready;
      pop = ce && out_valid && out_ready;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready = (cnt_q != CW'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

endmodule

// ===== core/sram_boundary_scan_tap.sv
// Scan test port of a synchronous memory: controller, instruction, bypass,
// identification and boundary registers, oversampling the scan clock pin.
// Assumes clock is much faster than the scan clock and that the ring pins
// are held stable around a capture when the snapshot must be exact.

// Contract
// - Inputs taken on scan clock rise, serial output changes on its fall.
// - Five rising edges with mode select high reach test-logic-reset.
// - Port reset never disturbs memory operation.
// - Power-up reset leaves serial output floating.
// - One register at a time sits between serial in and out, chosen by instruction.
// - Serial data enters at the top bit and leaves from bit zero.
// - Three-bit instruction, five codes used, three reserved.
// - Identification instruction loads at power-up and in test-logic-reset.
// - Capture-IR loads binary 01 into the low two instruction bits.
// - Bypass is one bit, cleared at Capture-DR while it is the selected register.
// - Boundary register covers all inputs: 73 bits wide part, 54 narrow.
// - Capture-DR loads the ring, Shift-DR shifts it.
// - Identification instruction captures the fixed 32-bit code and shifts it.
// - Instructions shift in Shift-IR and take effect at Update-IR.
// - All-zero code acts as sample and floats memory outputs.
// - Sample-with-float shifts the boundary register and floats memory outputs.
// - Sample instruction snapshots all inputs at Capture-DR.
// - Update-DR under sample does nothing, like Pause-DR.
// - Scan contents never drive memory pins; no preload.
module sram_boundary_scan_tap
   import tap_pkg::*;
#(
   parameter int BSR_LEN = BSR_LEN_X36,
   parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEF,
   parameter int SNAP_DEPTH = SNAP_DEPTH_DEF
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic tck_pin,
   input wire logic tms_pin,
   input wire logic tdi_pin,
   output logic tdo_out,
   output logic tdo_oe_n,
   input wire logic [BSR_LEN-1:0] ring_pins,
   output logic mem_hiz,
   output logic [IR_W-1:0] active_ir,
   output logic snap_room,
   output logic snap_valid,
   input wire logic snap_ready,
   output logic [BSR_LEN-1:0] snap_data
);

   // Next controller state from the present one and mode select
   function automatic tap_state_e tap_next(input tap_state_e s, input logic m);
      tap_state_e n;
      n = ST_RESET;
      unique case (s)
         ST_RESET: n = m ? ST_RESET : ST_IDLE;
         ST_IDLE: n = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: n = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: n = m ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR: n = m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: n = m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: n = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: n = m ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR: n = m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
         default: n = ST_RESET;
      endcase
      return n;
   endfunction

   // Data register chosen by an instruction; reserved codes fall to bypass
   function automatic dr_sel_e dr_select(input logic [IR_W-1:0] ir);
      dr_sel_e s;
      s = SEL_BYPASS;
      if (ir == IR_IDCODE) begin
         s = SEL_ID;
      end else if (ir == IR_SAMPLE || ir == IR_SAMPLE_Z || ir == IR_EXTEST) begin
         s = SEL_BSR;
      end
      return s;
   endfunction

   logic tck_s, tms_s, tdi_s;
   logic [BSR_LEN-1:0] ring_s;
   logic tck_last_q, tck_last_d;
   logic rise, fall;
   tap_state_e st_q, st_d;
   logic [IR_W-1:0] ir_q, ir_d;
   logic [IR_W-1:0] ir_sh_q, ir_sh_d;
   logic byp_q, byp_d;
   logic [ID_W-1:0] id_q, id_d;
   logic [BSR_LEN-1:0] bsr_q, bsr_d;
   logic tdo_q, tdo_d;
   logic oe_n_q, oe_n_d;
   dr_sel_e sel;
   logic snap_push;

   // Scan pins pass two flops; mode select and data idle high
   pin_sync #(.W(3), .RST(PIN_RST)) u_ctl_sync (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .async_in({tck_pin, tms_pin, tdi_pin}),
      .sync_out({tck_s, tms_s, tdi_s})
   );

   // Ring pins pass two flops before any capture
   pin_sync #(.W(BSR_LEN), .RST('0)) u_ring_sync (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .async_in(ring_pins),
      .sync_out(ring_s)
   );

   // Scan clock edge finder on the synchronised level
   always_comb begin
      tck_last_d = ce ? tck_s : tck_last_q;
      rise = ce && tck_s && !tck_last_q;
      fall = ce && !tck_s && tck_last_q;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tck_last_q <= 1'b0;
      end else begin
         tck_last_q <= tck_last_d;
      end
   end

   assign sel = dr_select(ir_q);

   // Controller and scan registers stepped on the scan clock rise; instruction forced to identification in reset on every enabled clock
   always_comb begin
      st_d = st_q;
      ir_d = ir_q;
      ir_sh_d = ir_sh_q;
      byp_d = byp_q;
      id_d = id_q;
      bsr_d = bsr_q;
      if (rise) begin
         st_d = tap_next(st_q, tms_s);
         if (st_q == ST_CAP_IR) begin
            ir_sh_d = {{(IR_W - 2){1'b0}}, IR_CAPTURE_PAT};
         end else if (st_q == ST_SH_IR) begin
            ir_sh_d = {tdi_s, ir_sh_q[IR_W-1:1]};
         end else if (st_q == ST_UPD_IR) begin
            ir_d = ir_sh_q;
         end else if (st_q == ST_CAP_DR) begin
            if (sel == SEL_BYPASS) begin
               byp_d = 1'b0;
            end else if (sel == SEL_ID) begin
               id_d = ID_VALUE;
            end else begin
               bsr_d = ring_s;
            end
         end else if (st_q == ST_SH_DR) begin
            if (sel == SEL_BYPASS) begin
               byp_d = tdi_s;
            end else if (sel == SEL_ID) begin
               id_d = {tdi_s, id_q[ID_W-1:1]};
            end else begin
               bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
            end
         end
         // Update-DR changes nothing: there is no preload stage
      end
      if (ce && st_q == ST_RESET) begin
         ir_d = IR_IDCODE;
      end
   end

   // Power-up reset: controller in test-logic-reset with identification loaded
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_RESET;
         ir_q <= IR_IDCODE;
         ir_sh_q <= '0;
         byp_q <= 1'b0;
         id_q <= '0;
         bsr_q <= '0;
      end else begin
         st_q <= st_d;
         ir_q <= ir_d;
         ir_sh_q <= ir_sh_d;
         byp_q <= byp_d;
         id_q <= id_d;
         bsr_q <= bsr_d;
      end
   end

   // Serial output: picked on the scan clock fall, driven only while shifting
   always_comb begin
      tdo_d = tdo_q;
      oe_n_d = oe_n_q;
      if (fall) begin
         if (st_q == ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
            oe_n_d = 1'b0;
         end else if (st_q == ST_SH_DR) begin
            oe_n_d = 1'b0;
            if (sel == SEL_BYPASS) begin
               tdo_d = byp_q;
            end else if (sel == SEL_ID) begin
               tdo_d = id_q[0];
            end else begin
               tdo_d = bsr_q[0];
            end
         end else begin
            oe_n_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tdo_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         tdo_q <= tdo_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign tdo_out = tdo_q;
   assign tdo_oe_n = oe_n_q;
   assign active_ir = ir_q;

   // Memory outputs float under the all-zero and sample-with-float codes only;
   // nothing else reaches the memory, so a port reset is harmless to it
   assign mem_hiz = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE_Z);

   // Every boundary capture is offered to the user side as a snapshot; one arriving while the FIFO is full is lost
   assign snap_push = rise && (st_q == ST_CAP_DR) && (sel == SEL_BSR);

   snap_fifo #(.W(BSR_LEN), .D(SNAP_DEPTH)) u_snap (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .in_valid(snap_push),
      .in_ready(snap_room),
      .in_data(ring_s),
      .out_valid(snap_valid),
      .out_ready(snap_ready),
      .out_data(snap_data)
   );

   // Helper: consecutive rises seen with mode select high, saturating
   logic [2:0] ones_q, ones_d;
   always_comb begin
      ones_d = ones_q;
      if (rise) begin
         ones_d = !tms_s ? 3'h0 : (ones_q == 3'(RESET_ONES)) ? ones_q : ones_q + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ones_q <= 3'h0;
      end else begin
         ones_q <= ones_d;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   sequence rise_in(tap_state_e s);
      rise && st_q == s;
   endsequence

   sequence shift_bsr;
      rise_in(ST_SH_DR) ##0 sel == SEL_BSR;
   endsequence

   a_five_ones_reset: assert property (
      rise && tms_s && ones_q == 3'(RESET_ONES - 1) |=> st_q == ST_RESET)
      else $error("five high mode clocks did not reach reset");

   a_reset_idcode: assert property (
      st_q == ST_RESET && ce |=> ir_q == IR_IDCODE)
      else $error("instruction not identification in reset");

   a_capir_pattern: assert property (
      rise_in(ST_CAP_IR) |=> ir_sh_q[1:0] == IR_CAPTURE_PAT)
      else $error("capture-ir pattern wrong");

   a_ir_holds: assert property (
      !(rise && st_q == ST_UPD_IR) && st_q != ST_RESET |=> $stable(ir_q))
      else $error("instruction changed outside update");

   a_ir_update: assert property (
      rise_in(ST_UPD_IR) |=> ir_q == $past(ir_sh_q))
      else $error("instruction not taken at update");

   a_tdo_on_fall: assert property (
      !fall |=> $stable(tdo_q) && $stable(oe_n_q))
      else $error("serial output moved off a falling edge");

   a_tdo_float: assert property (
      fall && st_q != ST_SH_DR && st_q != ST_SH_IR |=> tdo_oe_n)
      else $error("serial output driven outside shift");

   a_tdo_bsr_lsb: assert property (
      fall && st_q == ST_SH_DR && sel == SEL_BSR |=> !tdo_oe_n && tdo_out == $past(bsr_q[0]))
      else $error("serial output not boundary bit zero");

   a_bypass_clear: assert property (
      rise_in(ST_CAP_DR) ##0 sel == SEL_BYPASS |=> !byp_q)
      else $error("bypass not cleared at capture");

   a_id_capture: assert property (
      rise_in(ST_CAP_DR) ##0 sel == SEL_ID |=> id_q == ID_VALUE)
      else $error("identification not captured");

   a_bsr_capture: assert property (
      rise_in(ST_CAP_DR) ##0 sel == SEL_BSR |=> bsr_q == $past(ring_s) && snap_push == 1'b0)
      else $error("boundary snapshot wrong");

   a_bsr_shift: assert property (
      shift_bsr |=> bsr_q[BSR_LEN-1] == $past(tdi_s) && bsr_q[BSR_LEN-2:0] == $past(bsr_q[BSR_LEN-1:1]))
      else $error("boundary shift direction wrong");

   a_update_inert: assert property (
      rise_in(ST_UPD_DR) |=> $stable(bsr_q) && $stable(mem_hiz))
      else $error("update-dr had an effect");

   a_hiz_codes: assert property (
      rise_in(ST_UPD_IR) ##0 (ir_sh_q == IR_EXTEST || ir_sh_q == IR_SAMPLE_Z) |=> mem_hiz)
      else $error("memory outputs not floated");

   a_hiz_sample: assert property (
      rise_in(ST_UPD_IR) ##0 ir_sh_q == IR_SAMPLE |=> !mem_hiz)
      else $error("sample floated the memory outputs");

endmodule

// ===== tb/scan_host.sv
// Behavioural scan controller standing on the far side of the memory's scan port.
// Assumes the port oversamples its pins; pins move on system clock rises.
module scan_host
   import tap_pkg::*;
(
   input wire logic clock,
   output logic tck_pin,
   output logic tms_pin,
   output logic tdi_pin,
   input wire logic tdo_out,
   input wire logic tdo_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic tdo_line;

   // Released line shows the inverse of the last bit, so a lapse is caught
   assign tdo_line = tdo_oe_n ? ~tdo_out : tdo_out;

   // Idle levels follow the pin pull-ups; scan clock rests low
   initial begin
      tck_pin = 1'b0;
      tms_pin = 1'b1;
      tdi_pin = 1'b1;
   end

   // One scan clock period: fall, set up inputs, rise, sample serial out while high
   task automatic step(input logic m, input logic d, output logic q);
      tck_pin <= 1'b0;
      tms_pin <= m;
      tdi_pin <= d;
      repeat (4) @(posedge clock);
      tck_pin <= 1'b1;
      repeat (2) @(posedge clock);
      q = tdo_line; // Settled since the last fall
      repeat (2) @(posedge clock);
   endtask

   // Walk the controller with a mode-select pattern, first bit first
   task automatic walk(input logic [7:0] pat, input int n);
      logic q;
      for (int i = 0; i < n; i++) step(pat[i], 1'b1, q);
   endtask

   // Port reset by mode select held high, then park in Idle
   task automatic tap_reset();
      walk(8'h1f, RESET_ONES);
      walk(8'h00, 1);
   endtask

   // Load an instruction from Idle and return what the stage held at capture
   task automatic load_ir(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
      logic q;
      walk(8'h03, 4);
      // Callers only hand legal codes here
      for (int i = 0; i < IR_W; i++) begin
         step(i == IR_W - 1, code[i], q);
         cap[i] = q;
      end
      walk(8'h01, 3);
   endtask

   // Capture and shift n data bits from Idle; flags any lapse of the output enable
   task automatic scan_dr(input logic [127:0] din, input int n, output logic [127:0] dout, output logic bad);
      logic q;
      dout = '0;
      bad = 1'b0;
      walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
         bad |= (tdo_oe_n !== 1'b0);
      end
      walk(8'h01, 3);
      bad |= (tdo_oe_n !== 1'b1);
   endtask
endmodule

// ===== tb/test_sram_boundary_scan_tap.sv
// Self-checking bench for the memory's scan port, with a scan controller model.
// Assumes the package constants and the default identification value.
module test_sram_boundary_scan_tap
   import tap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BSR = BSR_LEN_X36;
   logic clock, arst_n, ce, tck_pin, tms_pin, tdi_pin, tdo_out, tdo_oe_n;
   logic mem_hiz, snap_room, snap_valid, snap_ready;
   logic [BSR-1:0] ring_pins, snap_data;
   logic [IR_W-1:0] active_ir;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [IR_W-1:0] codes [5] = '{IR_EXTEST, IR_IDCODE, IR_SAMPLE_Z, IR_SAMPLE, IR_BYPASS};

   sram_boundary_scan_tap #(.BSR_LEN(BSR)) dut (
      .clock(clock), .arst_n(arst_n), .ce(ce), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
      .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .ring_pins(ring_pins), .mem_hiz(mem_hiz),
      .active_ir(active_ir), .snap_room(snap_room), .snap_valid(snap_valid), .snap_ready(snap_ready),
      .snap_data(snap_data)
   );

   scan_host host (.clock(clock), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_out(tdo_out),
      .tdo_oe_n(tdo_oe_n));

   // System clock, 25 ns
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [127:0] rnd();
      return {$urandom, $urandom, $urandom, $urandom};
   endfunction

   function automatic int dr_len(input logic [IR_W-1:0] code);
      return (code == IR_IDCODE) ? ID_W : ((code == IR_BYPASS) ? 1 : BSR);
   endfunction

   // Captured word first, low bit first, then the shifted-in bits after it
   function automatic logic [127:0] exp_dr(input logic [IR_W-1:0] code, input logic [127:0] din,
                                           input logic [BSR-1:0] ring);
      logic [127:0] cap;
      int len;
      len = dr_len(code);
      cap = (code == IR_IDCODE) ? 128'(ID_VALUE_DEF) : ((code == IR_BYPASS) ? '0 : 128'(ring));
      return (cap | (din << len)) & ((128'h1 << (len + 8)) - 128'h1);
   endfunction

   // Main sequence
   initial begin
      logic [127:0] din, dout;
      logic [IR_W-1:0] cap;
      logic [IR_W-1:0] code;
      logic bad;
      logic [BSR-1:0] q_ring [$];
      arst_n = 1'b0;
      ce = 1'b1;
      ring_pins = '0;
      snap_ready = 1'b1;
      void'($urandom(32'h69d4));
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      #11;
      check("ir_after_reset", active_ir, IR_IDCODE);
      check("oe_after_reset", tdo_oe_n, 1'b1);
      // Identification read with no instruction load, 40 bits deep
      host.tap_reset();
      din = rnd();
      host.scan_dr(din, ID_W + 8, dout, bad);
      check("id_scan", dout, exp_dr(IR_IDCODE, din, ring_pins));
      // Every legal instruction twice, fresh ring and shift data each time
      repeat (2) foreach (codes[k]) begin
         code = codes[k];
         din = rnd();
         @(posedge clock) ring_pins <= din[BSR-1:0];
         #11;
         host.load_ir(code, cap);
         check("ir_capture", cap, 3'h1);
         check("ir_active", active_ir, code);
         check("mem_float", mem_hiz, code == IR_EXTEST || code == IR_SAMPLE_Z);
         din = rnd();
         host.scan_dr(din, dr_len(code) + 8, dout, bad);
         check("dr_scan", dout, exp_dr(code, din, ring_pins));
         check("tdo_enable", bad, 1'b0);
         check("ir_kept", active_ir, code);
      end
      // Port reset while outputs are floated returns to identification
      host.load_ir(IR_EXTEST, cap);
      host.tap_reset();
      check("ir_tap_reset", active_ir, IR_IDCODE);
      check("float_cleared", mem_hiz, 1'b0);
      // Snapshot stream: reader stalls while nine captures arrive
      host.load_ir(IR_SAMPLE, cap);
      @(posedge clock) snap_ready <= 1'b0;
      #11;
      for (int i = 0; i < 9; i++) begin
         din = rnd();
         @(posedge clock) ring_pins <= din[BSR-1:0];
         #11;
         if (i < 8)
            q_ring.push_back(ring_pins);
         host.scan_dr(din, 1, dout, bad);
      end
      check("fifo_full", snap_room, 1'b0);
      // Clock enable low: a read handshake must not pop a word
      @(posedge clock) begin
         ce <= 1'b0;
         snap_ready <= 1'b1;
      end
      repeat (4) @(posedge clock);
      ce <= 1'b1;
      snap_ready <= 1'b0;
      #11;
      check("ce_freeze", snap_room, 1'b0);
      // Drain in order, one word per handshake
      foreach (q_ring[i]) begin
         @(posedge clock);
         #1;
         check("snap_valid", snap_valid, 1'b1);
         check("snap_word", snap_data, q_ring[i]);
         @(posedge clock) snap_ready <= 1'b1;
         @(posedge clock) snap_ready <= 1'b0;
      end
      @(posedge clock);
      #1;
      check("fifo_empty", snap_valid, 1'b0);
      check("fifo_room", snap_room, 1'b1);
      stop_test();
   end
endmodule
